//--- itd_core.sv
// Instruction decode and cycle timing sequencer of the controller core
// Summary of operation
// - Carry/zero jumps, register loop: 2/3 cycles
// - Bit-test branches: three bytes, 3/4 cycles
// - Bit-test-and-clear branches and clears bit
// - Compare branches take 4/5 or 3/4
// - Direct decrement-branch: three bytes, 3/4 cycles
// - Short and indirect jumps take three cycles
// - Code byte reads: one byte, three cycles
// - External data moves: one byte, three cycles
// - Pointer immediate load: three bytes, three
// - Direct-to-direct move three; accumulator-register moves one
// - Low nibble exchange: one byte, two
// - Push and pop: two bytes, two
// - Accumulator rotates are single cycle
// - Carry-bit logic two; carry ops one
// - Register operand picks one of eight
// - Indirect address from first two registers
// - Relative target from next instruction address
// - Direct low half RAM, high half special
// - Page target replaces low eleven bits
// - Long target is full sixteen bits
// - Unused opcode behaves as no-operation
// - Alignment and read timing add cycles
// - Untaken branch finishes one cycle sooner
// - Bank select places banks at eight-byte steps
`timescale 1ns/100ps
module itd_core
	import itd_pkg::*;
(
	input  wire logic        CLK,          // System clock
	input  wire logic        RST,          // Synchronous reset, high
	input  wire logic        FETCH_VALID,  // Instruction bytes valid
	input  wire logic [7:0]  OPCODE,       // Opcode byte
	input  wire logic [7:0]  OPER1,        // First operand byte
	input  wire logic [7:0]  OPER2,        // Second operand byte
	input  wire logic        COND_TRUE,    // Branch condition holds
	input  wire logic [1:0]  BANK_SELECT,  // Bank select field
	input  wire logic [1:0]  FLASH_TIMING, // Flash read timing setting
	input  wire logic        MISALIGNED,   // Fetch crosses a line
	input  wire logic [15:0] RET_ADDR,     // Return or pointer target
	output logic             FETCH_REQ,    // Start of next fetch
	output logic [15:0]      PC,           // Program counter
	output logic [7:0]       REG_ADDR,     // Bank register address
	output logic [7:0]       PTR_ADDR,     // Indirect pointer address
	output logic             DIR_SFR,      // Direct hits special reg
	output logic             BIT_CLEAR,    // Clear tested bit pulse
	output logic             TAKEN,        // Branch taken flag
	output logic [3:0]       CYCLES        // Cycles of last instr
);

	// ************************************************************
	// Sequencer states
	// ************************************************************
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001, // Waiting for bytes
		ST_EXEC = 3'b010, // Counting execute cycles
		ST_DONE = 3'b100  // Issue next fetch
	} itd_state_t;

	itd_desc_t  desc;
	itd_oper_t  oper;
	itd_state_t state_reg,  state_next;
	logic [3:0] cnt_reg,    cnt_next;
	logic [3:0] total_reg,  total_next;
	logic [15:0] pc_reg,    pc_next;
	logic [15:0] tgt_reg,   tgt_next;
	logic       taken_reg,  taken_next;
	logic       clr_reg,    clr_next;
	logic       req_reg,    req_next;
	logic [7:0] ra_reg,     ra_next;
	logic [7:0] pa_reg,     pa_next;
	logic       sfr_reg,    sfr_next;
	logic [3:0] last_reg,   last_next;
	logic       take_now;

	// ************************************************************
	// Decoders
	// ************************************************************

	// Opcode table lookup
	itd_opdec u_opdec
	(
		.opcode (OPCODE),
		.desc   (desc)
	);

	// Operand address formation, direct address in first operand
	itd_operand u_operand
	(
		.opcode   (OPCODE),
		.dir_byte (OPER1),
		.bank_sel (BANK_SELECT),
		.oper     (oper)
	);

	// ************************************************************
	// Helpers
	// ************************************************************

	// Signed displacement added to the address after the branch
	function automatic logic [15:0] rel_target(input logic [15:0] nxt,
		input logic [7:0] disp);
		return 16'(nxt + {{8{disp[7]}}, disp});
	endfunction

	// Extra cycles from alignment and flash read timing
	function automatic logic [3:0] extra_cyc(input logic mis,
		input logic [1:0] flash_read_timing_setting);
		return mis ? {2'h0, flash_read_timing_setting} : 4'h0;
	endfunction

	// ************************************************************
	// Next-state logic
	// ************************************************************

	// Timing of one instruction, counted on rising edges:
	// edge 0 takes the bytes while idle and FETCH_VALID is high;
	// operand addresses, taken flag and clear pulse show after it.
	// The counter starts at one on that edge and steps once per
	// edge until it meets the total, then one done cycle follows.
	// The done cycle moves the target into PC, posts the total on
	// CYCLES and raises FETCH_REQ for exactly one cycle; the core
	// is idle again in that cycle and may take the next bytes.
	// The total is the base figure of the opcode, one more for a
	// taken branch, plus the read timing setting when the fetch
	// crosses a line. The penalty is a plain sum on purpose: the
	// true alignment effect depends on the fetch buffer outside
	// this block, and the caller decides when MISALIGNED is high.
	// Return and indirect targets are computed outside the core and
	// arrive on RET_ADDR with the bytes; nothing here checks them.
	// Bytes offered while busy are ignored without any indication,
	// so the fetch side must wait for FETCH_REQ before the next.

	// Works out cycle total and target once bytes arrive
	always_comb
	begin
		logic [15:0] nxt;
		logic [7:0]  disp;
		logic        tk;
		nxt        = 16'(pc_reg + {14'h0000, desc.nbytes});
		disp       = (desc.nbytes == 2'h3) ? OPER2 : OPER1;
		tk         = 1'b0;
		state_next = state_reg;
		cnt_next   = cnt_reg;
		total_next = total_reg;
		pc_next    = pc_reg;
		tgt_next   = tgt_reg;
		req_next   = 1'b0;
		last_next  = last_reg;
		case (state_reg)
			ST_IDLE:
			begin
				if (FETCH_VALID)
				begin
					tk       = desc.is_cond & COND_TRUE;
					tgt_next = nxt;
					case (desc.cls)
						CLS_FLAGBR, CLS_BITBR, CLS_BITCLR,
						CLS_CMPBR_L, CLS_CMPBR_S, CLS_DECBR_R,
						CLS_DECBR_D:
							if (tk)
								tgt_next = rel_target(nxt, disp);
						CLS_SHORT:
							tgt_next = rel_target(nxt, OPER1);
						CLS_INDIR, CLS_RET:
							tgt_next = RET_ADDR;
						CLS_PAGE:
							tgt_next = {nxt[15:PAGE_BITS],
								OPCODE[7:5], OPER1};
						CLS_LONG:
							tgt_next = {OPER1, OPER2};
						default:
							tgt_next = nxt;
					endcase
					// Taken adds one cycle to the not-taken base
					total_next = 4'(desc.cyc_base + {3'h0, tk}
						+ extra_cyc(MISALIGNED, FLASH_TIMING));
					cnt_next   = CYC_1;
					state_next = (total_next == CYC_1) ? ST_DONE : ST_EXEC;
				end
			end
			ST_EXEC:
			begin
				// Counting from the opcode fetch cycle
				cnt_next = 4'(cnt_reg + 4'h1);
				if (cnt_next == total_reg)
					state_next = ST_DONE;
			end
			ST_DONE:
			begin
				pc_next    = tgt_reg;
				req_next   = 1'b1;
				last_next  = total_reg;
				state_next = ST_IDLE;
			end
			default:
				state_next = ST_IDLE;
		endcase
	end

	// ************************************************************
	// State registers
	// ************************************************************

	// Registers only; reset gives an idle core at address zero
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			state_reg <= ST_IDLE;
			cnt_reg   <= CYC_RESET;
			total_reg <= CYC_RESET;
			pc_reg    <= PC_RESET;
			tgt_reg   <= PC_RESET;
			req_reg   <= 1'b0;
			last_reg  <= CYC_RESET;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			total_reg <= total_next;
			pc_reg    <= pc_next;
			tgt_reg   <= tgt_next;
			req_reg   <= req_next;
			last_reg  <= last_next;
		end
	end

	// ************************************************************
	// Operand capture
	// ************************************************************

	// Bytes are taken only while idle; the same condition gates the
	// sequencer, so capture and count always start on one edge
	assign take_now = (state_reg == ST_IDLE) && FETCH_VALID;

	// Capture is kept apart from the sequencer: these values stand
	// for the whole instruction and until the next take, while the
	// sequencer state moves every cycle. The clear pulse is the one
	// exception and lasts a single cycle.
	always_comb
	begin
		taken_next = taken_reg;
		clr_next   = 1'b0;
		ra_next    = ra_reg;
		pa_next    = pa_reg;
		sfr_next   = sfr_reg;
		if (take_now)
		begin
			taken_next = desc.is_cond & COND_TRUE;
			// Clearing rides only on a taken test-and-clear branch
			clr_next   = taken_next && desc.cls == CLS_BITCLR;
			ra_next    = oper.reg_addr;
			pa_next    = oper.ptr_addr;
			sfr_next   = oper.dir_is_sfr;
		end
	end

	// Capture registers; reset clears them with the sequencer
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			taken_reg <= 1'b0;
			clr_reg   <= 1'b0;
			ra_reg    <= 8'h00;
			pa_reg    <= 8'h00;
			sfr_reg   <= 1'b0;
		end
		else
		begin
			taken_reg <= taken_next;
			clr_reg   <= clr_next;
			ra_reg    <= ra_next;
			pa_reg    <= pa_next;
			sfr_reg   <= sfr_next;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************

	// Every output is a flop, so downstream logic never sees decode
	// glitches; the price is that each one shows a cycle after the
	// event that causes it, which the timing above already counts
	assign FETCH_REQ = req_reg;
	assign PC        = pc_reg;
	assign REG_ADDR  = ra_reg;
	assign PTR_ADDR  = pa_reg;
	assign DIR_SFR   = sfr_reg;
	assign BIT_CLEAR = clr_reg;
	assign TAKEN     = taken_reg;
	assign CYCLES    = last_reg;

endmodule

//--- itd_pkg.sv
// Package: shared types and constants for the instruction timing decoder
package itd_pkg;

	// ************************************************************
	// Instruction classes
	// ************************************************************
	typedef enum logic [4:0]
	{
		CLS_PLAIN    = 5'h00, // Fixed length and cycles
		CLS_FLAGBR   = 5'h01, // Carry / zero conditional jump
		CLS_BITBR    = 5'h02, // Bit test branch
		CLS_BITCLR   = 5'h03, // Bit test branch and clear
		CLS_CMPBR_L  = 5'h04, // Compare, long form
		CLS_CMPBR_S  = 5'h05, // Compare, short form
		CLS_DECBR_R  = 5'h06, // Decrement register and branch
		CLS_DECBR_D  = 5'h07, // Decrement direct and branch
		CLS_SHORT    = 5'h08, // Short relative jump
		CLS_INDIR    = 5'h09, // Jump indirect via pointer
		CLS_PAGE     = 5'h0a, // Page call or jump
		CLS_LONG     = 5'h0b, // Long call or jump
		CLS_RET      = 5'h0c  // Return
	} itd_class_t;

	// Decoded instruction descriptor
	typedef struct packed
	{
		itd_class_t cls;        // Instruction class
		logic [1:0] nbytes;     // Byte length
		logic [3:0] cyc_base;   // Cycles, not taken or fixed
		logic       is_cond;    // Conditional branch
		logic       uses_reg;   // Register operand in opcode
		logic       uses_ind;   // Indirect pointer operand
		logic       uses_dir;   // Direct address in byte 1
	} itd_desc_t;

	// Operand address results
	typedef struct packed
	{
		logic [7:0] reg_addr;   // Bank register RAM address
		logic [7:0] ptr_addr;   // Indirect pointer RAM address
		logic       dir_is_sfr; // Direct address is special reg
		logic [6:0] dir_ram;    // Direct RAM address
	} itd_oper_t;

	// ************************************************************
	// Constants
	// ************************************************************
	localparam logic [7:0] OP_NOP      = 8'h00;
	localparam logic [7:0] OP_UNUSED   = 8'ha5;
	localparam logic [3:0] BANK_STRIDE = 4'h8;
	localparam logic [3:0] CYC_RESET   = 4'h0;
	localparam logic [15:0] PC_RESET   = 16'h0000;
	localparam logic [1:0] RTIME_RESET = 2'h0;
	localparam int         PAGE_BITS   = 11;

	// Cycle figures
	localparam logic [3:0] CYC_1 = 4'h1;
	localparam logic [3:0] CYC_2 = 4'h2;
	localparam logic [3:0] CYC_3 = 4'h3;
	localparam logic [3:0] CYC_4 = 4'h4;
	localparam logic [3:0] CYC_5 = 4'h5;
	localparam logic [3:0] CYC_8 = 4'h8;

endpackage

//--- itd_opdec.sv
// Opcode decoder: byte length, base cycles and class of each opcode
`timescale 1ns/100ps
module itd_opdec
	import itd_pkg::*;
(
	input  wire logic [7:0] opcode, // Opcode byte
	output itd_desc_t       desc    // Decoded descriptor
);

	// ************************************************************
	// Decode table
	// ************************************************************

	// Helper builds a descriptor in one line
	function automatic itd_desc_t mk(input itd_class_t c,
		input logic [1:0] b, input logic [3:0] n, input logic cd);
		itd_desc_t d;
		d          = '0;
		d.cls      = c;
		d.nbytes   = b;
		d.cyc_base = n;
		d.is_cond  = cd;
		return d;
	endfunction

	// Rows keyed on low and high nibbles of the opcode
	always_comb
	begin
		logic [3:0] hi;
		logic [3:0] lo;
		hi   = opcode[7:4];
		lo   = opcode[3:0];
		desc = mk(CLS_PLAIN, 2'h1, CYC_1, 1'b0);
		if (opcode == OP_UNUSED)
			desc = mk(CLS_PLAIN, 2'h1, CYC_1, 1'b0);
		else if (lo == 4'h1)
			desc = mk(CLS_PAGE, 2'h2, CYC_3, 1'b0);
		else if (lo >= 4'h8)
		begin
			desc = mk(CLS_PLAIN, 2'h1, CYC_1, 1'b0);
			if (hi == 4'hb)
				desc = mk(CLS_CMPBR_S, 2'h3, CYC_3, 1'b1);
			else if (hi == 4'hd)
				desc = mk(CLS_DECBR_R, 2'h2, CYC_2, 1'b1);
			else if (hi == 4'h7 || hi == 4'ha || hi == 4'h8)
				desc = mk(CLS_PLAIN, 2'h2, CYC_2, 1'b0);
			desc.uses_reg = 1'b1;
		end
		else if (lo == 4'h6 || lo == 4'h7)
		begin
			desc = mk(CLS_PLAIN, 2'h1, CYC_2, 1'b0);
			if (hi == 4'hb)
				desc = mk(CLS_CMPBR_L, 2'h3, CYC_4, 1'b1);
			else if (hi == 4'h7 || hi == 4'h8 || hi == 4'ha)
				desc = mk(CLS_PLAIN, 2'h2, CYC_2, 1'b0);
			else if (hi == 4'hd)
				desc = mk(CLS_PLAIN, 2'h1, CYC_2, 1'b0);
			desc.uses_ind = 1'b1;
		end
		else if (lo == 4'h5)
		begin
			desc = mk(CLS_PLAIN, 2'h2, CYC_2, 1'b0);
			desc.uses_dir = 1'b1;
			if (hi == 4'hb)
				desc = mk(CLS_CMPBR_L, 2'h3, CYC_4, 1'b1);
			else if (hi == 4'hd)
				desc = mk(CLS_DECBR_D, 2'h3, CYC_3, 1'b1);
			else if (hi == 4'h8)
				desc = mk(CLS_PLAIN, 2'h3, CYC_3, 1'b0);
			desc.uses_dir = 1'b1;
		end
		else
		begin
			case (opcode)
				8'h00: desc = mk(CLS_PLAIN, 2'h1, CYC_1, 1'b0);
				8'h02: desc = mk(CLS_LONG, 2'h3, CYC_4, 1'b0);
				8'h12: desc = mk(CLS_LONG, 2'h3, CYC_4, 1'b0);
				8'h22: desc = mk(CLS_RET, 2'h1, CYC_5, 1'b0);
				8'h32: desc = mk(CLS_RET, 2'h1, CYC_5, 1'b0);
				8'h10: desc = mk(CLS_BITCLR, 2'h3, CYC_3, 1'b1);
				8'h20: desc = mk(CLS_BITBR, 2'h3, CYC_3, 1'b1);
				8'h30: desc = mk(CLS_BITBR, 2'h3, CYC_3, 1'b1);
				8'h40: desc = mk(CLS_FLAGBR, 2'h2, CYC_2, 1'b1);
				8'h50: desc = mk(CLS_FLAGBR, 2'h2, CYC_2, 1'b1);
				8'h60: desc = mk(CLS_FLAGBR, 2'h2, CYC_2, 1'b1);
				8'h70: desc = mk(CLS_FLAGBR, 2'h2, CYC_2, 1'b1);
				8'hb4: desc = mk(CLS_CMPBR_S, 2'h3, CYC_3, 1'b1);
				8'h80: desc = mk(CLS_SHORT, 2'h2, CYC_3, 1'b0);
				8'h73: desc = mk(CLS_INDIR, 2'h1, CYC_3, 1'b0);
				8'h83: desc = mk(CLS_PLAIN, 2'h1, CYC_3, 1'b0);
				8'h93: desc = mk(CLS_PLAIN, 2'h1, CYC_3, 1'b0);
				8'h90: desc = mk(CLS_PLAIN, 2'h3, CYC_3, 1'b0);
				8'he0, 8'he2, 8'he3,
				8'hf0, 8'hf2, 8'hf3:
					desc = mk(CLS_PLAIN, 2'h1, CYC_3, 1'b0);
				8'hc0, 8'hd0:
					desc = mk(CLS_PLAIN, 2'h2, CYC_2, 1'b0);
				8'h03, 8'h13, 8'h23, 8'h33:
					desc = mk(CLS_PLAIN, 2'h1, CYC_1, 1'b0);
				8'h72, 8'h82, 8'ha0, 8'hb0, 8'ha2, 8'h92:
					desc = mk(CLS_PLAIN, 2'h2, CYC_2, 1'b0);
				8'hb2, 8'hc2, 8'hd2:
					desc = mk(CLS_PLAIN, 2'h2, CYC_2, 1'b0);
				8'hb3, 8'hc3, 8'hd3:
					desc = mk(CLS_PLAIN, 2'h1, CYC_1, 1'b0);
				8'h43, 8'h53, 8'h63:
					desc = mk(CLS_PLAIN, 2'h3, CYC_3, 1'b0);
				8'h42, 8'h52, 8'h62, 8'h24, 8'h34, 8'h44,
				8'h54, 8'h64, 8'h74, 8'h94:
					desc = mk(CLS_PLAIN, 2'h2, CYC_2, 1'b0);
				8'ha4: desc = mk(CLS_PLAIN, 2'h1, CYC_4, 1'b0);
				8'h84: desc = mk(CLS_PLAIN, 2'h1, CYC_8, 1'b0);
				default: desc = mk(CLS_PLAIN, 2'h1, CYC_1, 1'b0);
			endcase
		end
	end

endmodule

//--- itd_operand.sv
// Operand address formation: bank registers, pointers, direct split
`timescale 1ns/100ps
module itd_operand
	import itd_pkg::*;
(
	input  wire logic [7:0] opcode,    // Opcode byte
	input  wire logic [7:0] dir_byte,  // Direct address operand byte
	input  wire logic [1:0] bank_sel,  // Bank select field
	output itd_oper_t       oper       // Operand addresses
);

	// ************************************************************
	// Address formation
	// ************************************************************

	// Bank base is bank number times the bank stride
	function automatic logic [7:0] bank_base(input logic [1:0] bs);
		return 8'({bs, 3'h0});
	endfunction

	// Register and pointer addresses sit inside the current bank
	always_comb
	begin
		oper            = '0;
		oper.reg_addr   = bank_base(bank_sel) | {5'h00, opcode[2:0]};
		oper.ptr_addr   = bank_base(bank_sel) | {7'h00, opcode[0]};
		oper.dir_is_sfr = dir_byte[7];
		oper.dir_ram    = dir_byte[6:0];
	end

endmodule

//--- itd_core_asserts.sv
// Checker: concurrent assertions on the decoder top ports
`timescale 1ns/100ps
module itd_core_asserts
	import itd_pkg::*;
(
	input wire logic        CLK,          // Clock
	input wire logic        RST,          // Reset
	input wire logic        FETCH_VALID,  // Bytes valid
	input wire logic [7:0]  OPCODE,       // Opcode
	input wire logic [7:0]  OPER1,        // Operand 1
	input wire logic [7:0]  OPER2,        // Operand 2
	input wire logic        COND_TRUE,    // Condition
	input wire logic [1:0]  BANK_SELECT,  // Bank
	input wire logic [1:0]  FLASH_TIMING, // Read timing
	input wire logic        MISALIGNED,   // Line cross
	input wire logic [15:0] RET_ADDR,     // Target
	input wire logic        FETCH_REQ,    // Next fetch
	input wire logic [15:0] PC,           // Counter
	input wire logic [7:0]  REG_ADDR,     // Reg addr
	input wire logic [7:0]  PTR_ADDR,     // Ptr addr
	input wire logic        DIR_SFR,      // Special
	input wire logic        BIT_CLEAR,    // Clear
	input wire logic        TAKEN,        // Taken
	input wire logic [3:0]  CYCLES        // Count
);
	// ************************************************************
	// Idle tracking, so a take can be told from an ignored strobe
	// ************************************************************
	logic idle_reg;
	logic idle_next;
	logic take;
	assign take = (idle_reg || FETCH_REQ) && FETCH_VALID;
	// Idle again once the next fetch is announced
	always_comb
	begin
		idle_next = idle_reg;
		if (take)
			idle_next = 1'b0;
		else if (FETCH_REQ)
			idle_next = 1'b1;
	end
	always_ff @(posedge CLK)
		idle_reg <= RST ? 1'b1 : idle_next;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	// ************************************************************
	// Assertions
	// ************************************************************
	a_req_pulse: assert property (FETCH_REQ |=> !FETCH_REQ)
		else $error("fetch request longer than one cycle");
	a_req_bounded: assert property (take |-> ##[2:12] FETCH_REQ)
		else $error("no fetch request after take");
	a_cycles_range: assert property (FETCH_REQ |->
		CYCLES >= CYC_1 && CYCLES <= CYC_8)
		else $error("cycle count out of range");
	a_reg_bank: assert property (take |=>
		REG_ADDR == {3'h0, $past(BANK_SELECT), $past(OPCODE[2:0])})
		else $error("register address wrong");
	a_ptr_pair: assert property (take |=>
		PTR_ADDR == {3'h0, $past(BANK_SELECT), 2'h0, $past(OPCODE[0])})
		else $error("pointer address wrong");
	a_dir_split: assert property (take |=>
		DIR_SFR == $past(OPER1[7]))
		else $error("direct split wrong");
	a_nop_alias: assert property (take && OPCODE == OP_UNUSED
		&& !MISALIGNED |-> ##2 (FETCH_REQ && CYCLES == CYC_1))
		else $error("unused opcode not a no-op");
	a_short_three: assert property (take && OPCODE == 8'h80
		&& !MISALIGNED |-> ##4 (FETCH_REQ && CYCLES == CYC_3))
		else $error("short jump not three cycles");
	a_jc_taken: assert property (take && OPCODE == 8'h40 |=>
		TAKEN == $past(COND_TRUE))
		else $error("taken flag wrong");
	a_clear_cause: assert property (BIT_CLEAR |-> $past(take) &&
		$past(OPCODE) == 8'h10 && $past(COND_TRUE) && TAKEN)
		else $error("bit clear without taken test");
	a_clear_pulse: assert property (BIT_CLEAR |=> !BIT_CLEAR)
		else $error("bit clear longer than one cycle");
endmodule

bind itd_core itd_core_asserts u_chk (.CLK(CLK), .RST(RST),
	.FETCH_VALID(FETCH_VALID), .OPCODE(OPCODE), .OPER1(OPER1),
	.OPER2(OPER2), .COND_TRUE(COND_TRUE), .BANK_SELECT(BANK_SELECT),
	.FLASH_TIMING(FLASH_TIMING), .MISALIGNED(MISALIGNED),
	.RET_ADDR(RET_ADDR), .FETCH_REQ(FETCH_REQ), .PC(PC),
	.REG_ADDR(REG_ADDR), .PTR_ADDR(PTR_ADDR), .DIR_SFR(DIR_SFR),
	.BIT_CLEAR(BIT_CLEAR), .TAKEN(TAKEN), .CYCLES(CYCLES));

//--- itd_prog_mem.sv
// Partner: program memory read at the decoder's counter
`timescale 1ns/100ps
module itd_prog_mem
	import itd_pkg::*;
(
	input  wire logic        clk,    // Clock
	input  wire logic        we,     // Load strobe
	input  wire logic [7:0]  waddr,  // Load address
	input  wire logic [23:0] wdata,  // Three bytes
	input  wire logic [15:0] addr,   // Read address
	input  wire logic        rd,     // Read enable
	output logic [7:0]       op,     // Opcode
	output logic [7:0]       b1,     // Operand 1
	output logic [7:0]       b2      // Operand 2
);
	logic [7:0] mem [256];
	logic       tgl_reg;
	// Load and idle toggle; low address bits only, aliasing is fine
	always_ff @(posedge clk)
	begin
		// No reset here, so an unknown start settles on the first edge
		tgl_reg <= (tgl_reg !== 1'b1);
		if (we)
		begin
			mem[waddr] <= wdata[7:0];
			mem[waddr + 8'h1] <= wdata[15:8];
			mem[waddr + 8'h2] <= wdata[23:16];
		end
	end
	// Released bus shows a moving pattern, never stale bytes
	always_comb
	begin
		op = rd ? mem[addr[7:0]] : {8{tgl_reg}} ^ 8'h3c;
		b1 = rd ? mem[addr[7:0] + 8'h1] : {8{tgl_reg}} ^ 8'hc3;
		b2 = rd ? mem[addr[7:0] + 8'h2] : {8{tgl_reg}} ^ 8'h5a;
	end
endmodule

//--- itd_core_tb.sv
// Testbench: random and table-driven instruction timing checks
`timescale 1ns/100ps
`define CHK(g, e) \
	begin \
		total_checks = total_checks + 1; \
		if ((g) !== (e)) \
		begin \
			num_errors = num_errors + 1; \
			$display("wrong value at %0t: %h %h", $time, g, e); \
		end \
	end
module itd_core_tb;
	import itd_pkg::*;
	localparam logic [7:0] OPS [40] = '{8'h40, 8'h50, 8'h60,
		8'h70, 8'hd9, 8'h20, 8'h30, 8'h10, 8'hd5,
		8'hb5, 8'hb6, 8'hb4, 8'hbb, 8'h80, 8'h73,
		8'h93, 8'h83, 8'he2, 8'hf3, 8'he0, 8'hf0,
		8'h90, 8'h85, 8'he8, 8'hd6, 8'hc0, 8'hd0,
		8'h23, 8'h33, 8'h03, 8'h13, 8'h82, 8'hb0,
		8'hc3, 8'hd3, 8'h61, 8'h31, 8'h02, 8'h12,
		8'ha5};
	logic clk, rst, fv, ct, mis, we, freq, dsfr, bclr, tkn;
	logic [1:0] bs, ft;
	logic [7:0] op, b1, b2, wa, ra8, pa8;
	logic [15:0] ret, pc, pc_exp;
	logic [23:0] wd;
	logic [3:0] cyc;
	logic [31:0] rng;
	int num_errors, total_checks, clr_cnt, cyc_cnt;
	itd_core DUT (.CLK(clk), .RST(rst), .FETCH_VALID(fv), .OPCODE(op),
		.OPER1(b1), .OPER2(b2), .COND_TRUE(ct), .BANK_SELECT(bs),
		.FLASH_TIMING(ft), .MISALIGNED(mis), .RET_ADDR(ret),
		.FETCH_REQ(freq), .PC(pc), .REG_ADDR(ra8), .PTR_ADDR(pa8),
		.DIR_SFR(dsfr), .BIT_CLEAR(bclr), .TAKEN(tkn), .CYCLES(cyc));
	itd_prog_mem u_mem (.clk(clk), .we(we), .waddr(wa), .wdata(wd),
		.addr(pc), .rd(fv), .op(op), .b1(b1), .b2(b2));
	// Xorshift source; a fixed seed keeps runs repeatable
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	// Expected {cond, kind, bytes, base cycles} of an opcode
	function automatic logic [9:0] info(input logic [7:0] o);
		casez (o)
			8'h40, 8'h50, 8'h60, 8'h70, 8'b1101_1???:
				return {1'b1, 3'h1, 2'h2, 4'h2};
			8'h10, 8'h20, 8'h30, 8'hd5, 8'hb4, 8'b1011_1???:
				return {1'b1, 3'h1, 2'h3, 4'h3};
			8'hb5, 8'hb6, 8'hb7: return {1'b1, 3'h1, 2'h3, 4'h4};
			8'h80: return {1'b0, 3'h1, 2'h2, 4'h3};
			8'h73: return {1'b0, 3'h4, 2'h1, 4'h3};
			8'h93, 8'h83, 8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3:
				return {1'b0, 3'h0, 2'h1, 4'h3};
			8'h90, 8'h85: return {1'b0, 3'h0, 2'h3, 4'h3};
			8'hd6, 8'hd7: return {1'b0, 3'h0, 2'h1, 4'h2};
			8'hc0, 8'hd0, 8'h82, 8'hb0: return {1'b0, 3'h0, 2'h2, 4'h2};
			8'b????_0001: return {1'b0, 3'h2, 2'h2, 4'h3};
			8'h02, 8'h12: return {1'b0, 3'h3, 2'h3, 4'h4};
			default: return {1'b0, 3'h0, 2'h1, 4'h1};
		endcase
	endfunction
	// Verdict and end of run
	task close_out;
		if (num_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// One instruction: load memory, strobe, wait, compare
	task run_one(input logic [7:0] o, input int mode);
		logic [9:0] inf;
		logic c, m;
		logic [7:0] o1, o2, d;
		logic [15:0] ra, nx;
		logic [3:0] n;
		int lat, clr0;
		rng = xs(rng);
		c = (mode == 1) ? 1'b1 : (mode == 2) ? 1'b0 : rng[0];
		m = (mode == 1) ? 1'b0 : (mode == 2) ? 1'b1 : rng[1];
		o1 = rng[15:8];
		o2 = rng[23:16];
		ra = rng[31:16];
		inf = info(o);
		d = (inf[5:4] == 2'h3) ? o2 : o1;
		n = inf[3:0] + {3'h0, inf[9] & c} + (m ? {2'h0, rng[3:2]} : 4'h0);
		nx = pc_exp + {14'h0, inf[5:4]};
		case (inf[8:6])
			3'h1: if (!inf[9] || c) nx = nx + {{8{d[7]}}, d};
			3'h2: nx = {nx[15:11], o[7:5], o1};
			3'h3: nx = {o1, o2};
			3'h4: nx = ra;
			default: ;
		endcase
		@(posedge clk);
		we <= 1'b1;
		wa <= pc_exp[7:0];
		wd <= {o2, o1, o};
		@(posedge clk);
		we <= 1'b0;
		fv <= 1'b1;
		ct <= c;
		mis <= m;
		ft <= rng[3:2];
		bs <= rng[5:4];
		ret <= ra;
		@(posedge clk);
		fv <= 1'b0;
		#1;
		clr0 = clr_cnt;
		lat = 0;
		while (freq !== 1'b1 && lat < 12)
		begin
			@(posedge clk);
			#1;
			lat++;
		end
		`CHK(freq, 1'b1)
		`CHK(cyc, n)
		`CHK(pc, nx)
		if (inf[9]) `CHK(tkn, c)
		`CHK(ra8, {3'h0, rng[5:4], o[2:0]})
		`CHK(pa8, {3'h0, rng[5:4], 2'h0, o[0]})
		`CHK(dsfr, o1[7])
		`CHK(clr_cnt != clr0, o == 8'h10 && c)
		pc_exp = nx;
	endtask
	// Clock and cycle ceiling
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = !clk;
	end
	always @(posedge clk)
	begin
		cyc_cnt++;
		if (bclr === 1'b1)
			clr_cnt++;
		if (cyc_cnt == 10000)
		begin
			num_errors++;
			close_out;
		end
	end
	// Reset, table sweeps with forced corners, then random stream
	initial
	begin
		{rst, fv, ct, mis, we, bs, ft, wa, wd, ret} = '0;
		rst = 1'b1;
		rng = 32'h6476;
		pc_exp = PC_RESET;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		`CHK(pc, PC_RESET)
		`CHK(cyc, CYC_RESET)
		for (int k = 1; k <= 2; k++)
			foreach (OPS[i]) run_one(OPS[i], k);
		repeat (150)
		begin
			rng = xs(rng);
			run_one(OPS[rng[15:8] % 40], 0);
		end
		close_out;
	end
endmodule
